// [ldp_i2c_slave.sv]
// I2C register-port slave: pointer byte, auto-increment reads and writes.
// Assumes SCL and SDA already synchronous to sys_clk; SDA is open drain.
module ldp_i2c_slave (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic [7:0] rd_data,
    output logic [7:0] reg_ptr,
    output logic wr_en,
    output logic [7:0] wr_data,
    output logic sda_out,
    output logic sda_oe
);
    import ldp_pkg::*;
    typedef struct packed {
        logic scl_d;
        logic sda_d;
        ldp_i2c_t st;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic rw;
        logic nack;
        logic oe;
        logic we;
        logic [7:0] wd;
    } ldp_i2c_state_t;
    ldp_i2c_state_t s_r, s_nxt;
    logic rise, fall, start, stop;

    // Bus events from the previous line levels
    assign rise = scl & ~s_r.scl_d;
    assign fall = ~scl & s_r.scl_d;
    assign start = scl & s_r.scl_d & s_r.sda_d & ~sda_in;
    assign stop = scl & s_r.scl_d & ~s_r.sda_d & sda_in;

    // Protocol engine; data changes only on SCL falling edges
    always_comb begin
        s_nxt = s_r;
        s_nxt.we = 1'b0;
        s_nxt.scl_d = scl;
        s_nxt.sda_d = sda_in;
        if (start) begin
            s_nxt.st = I_ADR;
            s_nxt.bits = 4'h0;
            s_nxt.oe = 1'b0;
        end else if (stop) begin
            s_nxt.st = I_IDLE;
            s_nxt.oe = 1'b0;
        end else if (rise) begin
            if (s_r.st == I_ADR || s_r.st == I_PTR || s_r.st == I_WDAT) begin
                s_nxt.sh = {s_r.sh[6:0], sda_in};
                s_nxt.bits = s_r.bits + 4'h1;
            end else if (s_r.st == I_RACK) begin
                s_nxt.nack = sda_in;
            end
        end else if (fall) begin
            unique case (s_r.st)
                I_IDLE: ;
                I_ADR: if (s_r.bits == 4'h8) begin
                    // Silent on a foreign address
                    s_nxt.st = (s_r.sh[7:1] == DEV_ADDR) ? I_AACK : I_IDLE;
                    s_nxt.oe = (s_r.sh[7:1] == DEV_ADDR);
                    s_nxt.rw = s_r.sh[0];
                end
                I_AACK, I_RACK: begin
                    s_nxt.bits = 4'h0;
                    if (s_r.st == I_RACK && s_r.nack) begin
                        s_nxt.st = I_IDLE;
                        s_nxt.oe = 1'b0;
                    end else if (s_r.st == I_RACK || s_r.rw) begin
                        s_nxt.st = I_RDAT;
                        s_nxt.sh = rd_data;
                        s_nxt.oe = ~rd_data[7];
                    end else begin
                        s_nxt.st = I_PTR;
                        s_nxt.oe = 1'b0;
                    end
                end
                I_PTR: if (s_r.bits == 4'h8) begin
                    s_nxt.ptr = s_r.sh;
                    s_nxt.st = I_PACK;
                    s_nxt.oe = 1'b1;
                end
                I_PACK, I_WACK: begin
                    s_nxt.st = I_WDAT;
                    s_nxt.bits = 4'h0;
                    s_nxt.oe = 1'b0;
                end
                I_WDAT: if (s_r.bits == 4'h8) begin
                    s_nxt.we = 1'b1;
                    s_nxt.wd = s_r.sh;
                    s_nxt.ptr = s_r.ptr + 8'h01;
                    s_nxt.st = I_WACK;
                    s_nxt.oe = 1'b1;
                end
                I_RDAT: if (s_r.bits == 4'h7) begin
                    s_nxt.st = I_RACK;
                    s_nxt.oe = 1'b0;
                    s_nxt.ptr = s_r.ptr + 8'h01;
                end else begin
                    s_nxt.sh = {s_r.sh[6:0], 1'b0};
                    s_nxt.oe = ~s_r.sh[6];
                    s_nxt.bits = s_r.bits + 4'h1;
                end
                default: s_nxt.st = I_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= '{scl_d: 1'b1, sda_d: 1'b1, st: I_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // The write pulse lags the stored pointer, so send the pre-increment one
    assign reg_ptr = s_r.we ? s_r.ptr - 8'h01 : s_r.ptr;
    assign wr_en = s_r.we;
    assign wr_data = s_r.wd;
    assign sda_out = 1'b0;
    assign sda_oe = s_r.oe;
endmodule

// [ldp_ldo_ctrl.sv]
// Second LDO control and shared LDO settings, reached over I2C.
// Assumes comparator and mode inputs are synchronous to sys_clk.
// Notes on behaviour
// - Bit 7 shows live power-good compare
// - Bit 6 reads 0 above overvoltage threshold
// - Bit 5 shows live current-limit compare
// - UV mask keeps fault from master
// - OV mask keeps fault from master
// - Limit mask keeps fault from master
// - Eight-bit voltage code drives the regulator
// - Read-only factory reference select, bit 6
// - Direct enable bit bypasses startup sequence
// - Aux input controls regulator when enabled
// - Sleep-off bit turns regulator off
// - Deep-sleep-off bit turns regulator off
// - Turn-off waits code times quarter millisecond
// - Turn-on delay 0, 0.25, 0.5, 1 ms
// - Reset link pulls aux reset low
// - Latch bit keeps regulator on after sequencing
// - Two-bit current-limit codes per regulator
// - Second regulator limit shutdown, retry 14 ms
// - First regulator limit shutdown, retry 14 ms
module ldp_ldo_ctrl #(
    parameter int unsigned RETRY_CYCLES = ldp_pkg::RETRY_CYC_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic i2c_scl,
    input wire logic i2c_sda_in,
    input wire logic ldo_b_pg_cmp,
    input wire logic ldo_b_ov_below,
    input wire logic ldo_b_ilim_cmp,
    input wire logic ldo_b_undervoltage_fault,
    input wire logic ldo_a_ilim_cmp,
    input wire logic ldo_b_seq_en,
    input wire logic ldo_b_direct_permit,
    input wire logic aux_in,
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    output logic i2c_sda_out,
    output logic i2c_sda_oe,
    output logic ldo_b_en,
    output logic [7:0] ldo_b_voltage_code,
    output logic [1:0] ldo_b_limit_code,
    output logic [1:0] ldo_a_limit_code,
    output logic ldo_a_latch_on,
    output logic ldo_a_limit_off,
    output logic ldo_vref_sel,
    output logic aux_reset_out_n,
    output logic master_uv_fault_ldo_b,
    output logic master_ov_fault_ldo_b,
    output logic master_limit_fault_ldo_b
);
    import ldp_pkg::*;

    typedef struct packed {
        logic [2:0] mask;
        logic [7:0] vset;
        logic [7:0] enc;
        logic [7:0] offc;
        logic [7:0] onc;
        logic [7:0] lat;
        logic vref;
        ldp_fsm_t fsm;
        logic [17:0] cnt;
        logic en;
        logic rst_n;
        logic uv_f;
        logic ov_f;
        logic lim_f;
        logic a_off;
        logic [17:0] a_cnt;
    } ldp_state_t;

    ldp_state_t s_r, s_nxt;
    logic [7:0] reg_ptr, wr_data, rd_data;
    logic wr_en, seq_hold, low_pwr_off, direct, req, b_trip, a_trip;
    logic [17:0] on_tgt, off_tgt, cnt_inc;

    localparam logic [17:0] RETRY_LAST = 18'(RETRY_CYCLES - 1);

    // Register read decode, shared by the port and the checks
    function automatic logic [7:0] reg_read(input logic [7:0] a, input ldp_state_t s,
                                            input logic pg, input logic ov, input logic il);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            A_STAT: d = {pg, ov, il, 1'b0, s.mask, 1'b0};
            A_VSET: d = s.vset;
            A_ENC: d = s.enc;
            A_OFFC: d = s.offc;
            A_ONC: d = s.onc;
            A_REF: d = {1'b0, s.vref, 6'h00};
            A_LAT: d = s.lat;
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // Turn-on delay table in cycles
    function automatic logic [17:0] on_delay(input logic [1:0] code);
        logic [17:0] c;
        c = 18'h0;
        unique case (code)
            2'b00: c = 18'h0;
            2'b01: c = 18'(Q_CYC);
            2'b10: c = 18'(2 * Q_CYC);
            2'b11: c = 18'(4 * Q_CYC);
        endcase
        return c;
    endfunction

    ldp_i2c_slave u_i2c (
        .sys_clk(sys_clk),
        .reset(reset),
        .scl(i2c_scl),
        .sda_in(i2c_sda_in),
        .rd_data(rd_data),
        .reg_ptr(reg_ptr),
        .wr_en(wr_en),
        .wr_data(wr_data),
        .sda_out(i2c_sda_out),
        .sda_oe(i2c_sda_oe)
    );

    assign rd_data = reg_read(reg_ptr, s_r, ldo_b_pg_cmp, ldo_b_ov_below, ldo_b_ilim_cmp);

    // Enable request; latch keeps an on regulator on after sequencing drops
    assign seq_hold = ldo_b_seq_en | (s_r.lat[B_BLAT] & s_r.en);
    assign low_pwr_off = (sleep_mode & s_r.enc[B_SLP])
                       | (deep_sleep_mode & s_r.enc[B_DSLP]);
    assign direct = s_r.enc[B_DIR] & ldo_b_direct_permit;
    // Aux input replaces the sequenced request only when allowed
    assign req = direct | ((s_r.enc[B_AUX] ? aux_in : seq_hold) & ~low_pwr_off);
    assign b_trip = ldo_b_ilim_cmp & ~s_r.lat[B_BSDO] & s_r.en;
    assign a_trip = ldo_a_ilim_cmp & ~s_r.lat[B_ASDO] & ~s_r.a_off;
    assign on_tgt = on_delay(s_r.onc[1:0]);
    assign off_tgt = 18'(s_r.offc[7:3] * Q_CYC);
    assign cnt_inc = s_r.cnt + 18'h1;

    // Next state: register writes, sequencer, faults, first-LDO retry
    always_comb begin
        s_nxt = s_r;
        if (wr_en) begin
            unique case (reg_ptr)
                A_STAT: s_nxt.mask = wr_data[3:1];
                A_VSET: s_nxt.vset = wr_data;
                A_ENC: s_nxt.enc = wr_data;
                A_OFFC: s_nxt.offc = wr_data;
                A_ONC: s_nxt.onc = wr_data;
                A_LAT: s_nxt.lat = wr_data;
                default: ; // Read-only or unmapped: ignored
            endcase
        end
        // Regulator sequencer
        unique case (s_r.fsm)
            F_OFF: if (req) begin
                s_nxt.cnt = 18'h0;
                s_nxt.fsm = (on_tgt == 18'h0) ? F_ON : F_ONW;
            end
            F_ONW: begin
                s_nxt.cnt = cnt_inc;
                if (!req) begin
                    s_nxt.fsm = F_OFF;
                end else if (cnt_inc >= on_tgt) begin
                    s_nxt.fsm = F_ON;
                end
            end
            F_ON: begin
                s_nxt.cnt = 18'h0;
                if (b_trip) begin
                    s_nxt.fsm = F_RTRY;
                end else if (!req) begin
                    s_nxt.fsm = (off_tgt == 18'h0) ? F_OFF : F_OFFW;
                end
            end
            F_OFFW: begin
                s_nxt.cnt = cnt_inc;
                if (b_trip) begin
                    s_nxt.cnt = 18'h0;
                    s_nxt.fsm = F_RTRY;
                end else if (req) begin
                    s_nxt.fsm = F_ON;
                end else if (cnt_inc >= off_tgt) begin
                    s_nxt.fsm = F_OFF;
                end
            end
            F_RTRY: begin
                // Restart goes back through the normal turn-on path
                s_nxt.cnt = cnt_inc;
                if (s_r.cnt >= RETRY_LAST) begin
                    s_nxt.fsm = F_OFF;
                end
            end
            default: s_nxt.fsm = F_OFF;
        endcase
        s_nxt.en = (s_nxt.fsm == F_ON) || (s_nxt.fsm == F_OFFW);
        s_nxt.rst_n = ~(s_r.onc[B_RLNK] & ~s_nxt.en);
        // Unmasked faults reach the master fault registers
        s_nxt.uv_f = ldo_b_undervoltage_fault & ~s_r.mask[2];
        s_nxt.ov_f = ~ldo_b_ov_below & ~s_r.mask[1];
        s_nxt.lim_f = ldo_b_ilim_cmp & ~s_r.mask[0];
        // First LDO limit shutdown and timed restart
        if (a_trip) begin
            s_nxt.a_off = 1'b1;
            s_nxt.a_cnt = 18'h0;
        end else if (s_r.a_off) begin
            s_nxt.a_cnt = s_r.a_cnt + 18'h1;
            if (s_r.a_cnt >= RETRY_LAST) begin
                s_nxt.a_off = 1'b0;
            end
        end
    end

    // Factory reference select is a reset constant and never written
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_r <= '{mask: R_STAT[3:1], vset: R_VSET, enc: R_ENC, offc: R_OFFC, onc: R_ONC,
                     lat: R_LAT, vref: R_REF[B_VREF], fsm: F_OFF, rst_n: 1'b0, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign ldo_b_en = s_r.en;
    assign ldo_b_voltage_code = s_r.vset;
    assign ldo_b_limit_code = s_r.lat[5:4];
    assign ldo_a_limit_code = s_r.lat[3:2];
    assign ldo_a_latch_on = s_r.lat[6];
    assign ldo_a_limit_off = s_r.a_off;
    assign ldo_vref_sel = s_r.vref;
    assign aux_reset_out_n = s_r.rst_n;
    assign master_uv_fault_ldo_b = s_r.uv_f;
    assign master_ov_fault_ldo_b = s_r.ov_f;
    assign master_limit_fault_ldo_b = s_r.lim_f;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    property p_pg_live;
        (reg_ptr == A_STAT) |-> (rd_data[7] == ldo_b_pg_cmp && rd_data[5] == ldo_b_ilim_cmp);
    endproperty
    a_pg_live: assert property (p_pg_live) else $error("live status bits wrong");

    property p_ov_live;
        (reg_ptr == A_STAT) |-> (rd_data[6] == ldo_b_ov_below);
    endproperty
    a_ov_live: assert property (p_ov_live) else $error("overvoltage status wrong");

    property p_uv_mask;
        ##1 master_uv_fault_ldo_b == ($past(ldo_b_undervoltage_fault) & ~$past(s_r.mask[2]));
    endproperty
    a_uv_mask: assert property (p_uv_mask) else $error("uv fault mask wrong");

    property p_ov_mask;
        (s_r.mask[1] && !wr_en) |=> !master_ov_fault_ldo_b;
    endproperty
    a_ov_mask: assert property (p_ov_mask) else $error("ov fault not masked");

    property p_lim_mask;
        (!s_r.mask[0] && ldo_b_ilim_cmp) |=> master_limit_fault_ldo_b;
    endproperty
    a_lim_mask: assert property (p_lim_mask) else $error("limit fault lost");

    property p_vset_write;
        (wr_en && reg_ptr == A_VSET) |=> ldo_b_voltage_code == $past(wr_data);
    endproperty
    a_vset_write: assert property (p_vset_write) else $error("voltage code not stored");

    property p_vref_fixed;
        ##1 $stable(ldo_vref_sel) && ldo_vref_sel == R_REF[6];
    endproperty
    a_vref_fixed: assert property (p_vref_fixed) else $error("reference select changed");

    property p_off_delay;
        (s_r.fsm == F_ON && !req && !b_trip && off_tgt != 18'h0) |=> ldo_b_en ##1 (ldo_b_en || $past(b_trip));
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("turn-off delay skipped");

    property p_on_nodelay;
        (s_r.fsm == F_OFF && req && s_r.onc[1:0] == 2'b00) |=> ldo_b_en;
    endproperty
    a_on_nodelay: assert property (p_on_nodelay) else $error("zero turn-on delay late");

    property p_rst_link;
        (s_r.onc[B_RLNK] && s_r.fsm == F_OFF && !req && !wr_en) |=> !aux_reset_out_n;
    endproperty
    a_rst_link: assert property (p_rst_link) else $error("aux reset not asserted");

    property p_b_trip;
        b_trip |=> !ldo_b_en ##1 !ldo_b_en;
    endproperty
    a_b_trip: assert property (p_b_trip) else $error("limit shutdown missed");

    property p_a_trip;
        a_trip |=> ldo_a_limit_off [*3];
    endproperty
    a_a_trip: assert property (p_a_trip) else $error("first regulator not shut down");
endmodule

// [ldp_pkg.sv]
// Shared constants for the LDO pair control block.
// Assumes a 10 MHz sys_clk and an I2C port sampled on it.
package ldp_pkg;
    // Register byte addresses
    localparam logic [7:0] A_STAT = 8'ha6;
    localparam logic [7:0] A_VSET = 8'ha7;
    localparam logic [7:0] A_ENC = 8'ha8;
    localparam logic [7:0] A_OFFC = 8'ha9;
    localparam logic [7:0] A_ONC = 8'haa;
    localparam logic [7:0] A_REF = 8'hac;
    localparam logic [7:0] A_LAT = 8'had;
    // Reset values
    localparam logic [7:0] R_STAT = 8'h0e;
    localparam logic [7:0] R_VSET = 8'hff;
    localparam logic [7:0] R_ENC = 8'hc0;
    localparam logic [7:0] R_OFFC = 8'h31;
    localparam logic [7:0] R_ONC = 8'h0c;
    localparam logic [7:0] R_REF = 8'h00;
    localparam logic [7:0] R_LAT = 8'h3f;
    // Field positions
    localparam int B_PG = 7;
    localparam int B_OV = 6;
    localparam int B_IL = 5;
    localparam int B_DIR = 7;
    localparam int B_AUX = 5;
    localparam int B_SLP = 4;
    localparam int B_DSLP = 3;
    localparam int B_RLNK = 2;
    localparam int B_VREF = 6;
    localparam int B_BLAT = 7;
    localparam int B_BSDO = 1;
    localparam int B_ASDO = 0;
    // Timing
    localparam int unsigned CLK_NS = 100;
    localparam int unsigned QMS_NS = 250000;
    localparam int unsigned Q_CYC = (QMS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned RETRY_MS = 14;
    localparam int unsigned RETRY_CYC_DEF = RETRY_MS * 1000000 / CLK_NS;
    // Bus address of this device; value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    typedef enum logic [2:0] {
        F_OFF = 3'b000, F_ONW = 3'b001, F_ON = 3'b011, F_OFFW = 3'b010, F_RTRY = 3'b110
    } ldp_fsm_t;
    typedef enum logic [3:0] {
        I_IDLE = 4'h0, I_ADR = 4'h1, I_AACK = 4'h3, I_PTR = 4'h2, I_PACK = 4'h6,
        I_WDAT = 4'h7, I_WACK = 4'h5, I_RDAT = 4'h4, I_RACK = 4'hc
    } ldp_i2c_t;
endpackage

// [ldp_tb.sv]
// Self-checking bench for the LDO pair control block: registers over I2C, enable paths.
// Assumes ldp_pkg is compiled first; the bench plays the I2C master and the analog side.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ldp_pkg::*;

    localparam int RTRY = 20;

    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic i2c_scl = 1'b1;
    logic sda_low = 1'b0;
    logic ldo_b_pg_cmp = 1'b0;
    logic ldo_b_ov_below = 1'b0;
    logic ldo_b_ilim_cmp = 1'b0;
    logic ldo_b_undervoltage_fault = 1'b0;
    logic ldo_a_ilim_cmp = 1'b0;
    logic ldo_b_seq_en = 1'b0;
    logic ldo_b_direct_permit = 1'b0;
    logic aux_in = 1'b0;
    logic sleep_mode = 1'b0;
    logic deep_sleep_mode = 1'b0;
    logic i2c_sda_out, i2c_sda_oe, ldo_b_en, ldo_a_latch_on, ldo_a_limit_off, ldo_vref_sel;
    logic aux_reset_out_n, master_uv_fault_ldo_b, master_ov_fault_ldo_b, master_limit_fault_ldo_b;
    logic [7:0] ldo_b_voltage_code;
    logic [1:0] ldo_b_limit_code, ldo_a_limit_code;
    logic sda_line;
    int fails = 0;
    int samples_checked = 0;

    // Open-drain wire with pull-up: low when either party pulls
    assign sda_line = !(sda_low || (i2c_sda_oe && !i2c_sda_out));

    ldp_ldo_ctrl #(.RETRY_CYCLES(RTRY)) uut (
        .sys_clk(sys_clk), .reset(reset), .i2c_scl(i2c_scl), .i2c_sda_in(sda_line),
        .ldo_b_pg_cmp(ldo_b_pg_cmp), .ldo_b_ov_below(ldo_b_ov_below), .ldo_b_ilim_cmp(ldo_b_ilim_cmp),
        .ldo_b_undervoltage_fault(ldo_b_undervoltage_fault), .ldo_a_ilim_cmp(ldo_a_ilim_cmp),
        .ldo_b_seq_en(ldo_b_seq_en), .ldo_b_direct_permit(ldo_b_direct_permit), .aux_in(aux_in),
        .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode), .i2c_sda_out(i2c_sda_out),
        .i2c_sda_oe(i2c_sda_oe), .ldo_b_en(ldo_b_en), .ldo_b_voltage_code(ldo_b_voltage_code),
        .ldo_b_limit_code(ldo_b_limit_code), .ldo_a_limit_code(ldo_a_limit_code),
        .ldo_a_latch_on(ldo_a_latch_on), .ldo_a_limit_off(ldo_a_limit_off), .ldo_vref_sel(ldo_vref_sel),
        .aux_reset_out_n(aux_reset_out_n), .master_uv_fault_ldo_b(master_uv_fault_ldo_b),
        .master_ov_fault_ldo_b(master_ov_fault_ldo_b), .master_limit_fault_ldo_b(master_limit_fault_ldo_b)
    );

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One SCL pulse; data set 2 clocks after the fall, sampled late in the high phase
    task automatic clk_bit(input logic drive_low, output logic line);
        sda_low <= drive_low;
        cyc(5);
        i2c_scl <= 1'b1;
        cyc(5);
        line = sda_line;
        i2c_scl <= 1'b0;
        cyc(2);
    endtask

    // Also serves as repeated start, since SCL is low between bytes
    task automatic i2c_start;
        sda_low <= 1'b0;
        cyc(5);
        i2c_scl <= 1'b1;
        cyc(5);
        sda_low <= 1'b1;
        cyc(5);
        i2c_scl <= 1'b0;
        cyc(2);
    endtask

    task automatic i2c_stop;
        sda_low <= 1'b1;
        cyc(5);
        i2c_scl <= 1'b1;
        cyc(5);
        sda_low <= 1'b0;
        cyc(5);
    endtask

    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic l;
        for (int i = 7; i >= 0; i--) clk_bit(~b[i], l);
        clk_bit(1'b0, ack);
    endtask

    task automatic byte_in(input logic nack, output logic [7:0] d);
        logic l;
        for (int i = 7; i >= 0; i--) clk_bit(1'b0, d[i]);
        clk_bit(~nack, l);
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        logic ack;
        i2c_start();
        byte_out({DEV_ADDR, 1'b0}, ack);
        chk(ack, 0);
        byte_out(a, ack);
        chk(ack, 0);
        byte_out(d, ack);
        chk(ack, 0);
        i2c_stop();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic ack;
        logic [7:0] d;
        i2c_start();
        byte_out({DEV_ADDR, 1'b0}, ack);
        byte_out(a, ack);
        i2c_start();
        byte_out({DEV_ADDR, 1'b1}, ack);
        chk(ack, 0);
        byte_in(1'b1, d);
        i2c_stop();
        chk(d, exp);
    endtask

    // Counts edges until the enable reaches tgt; accepts lo..hi
    task automatic wait_en(input logic tgt, input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (ldo_b_en !== tgt && n <= hi);
        chk((n >= lo && n <= hi) ? lo : n, lo);
        // Realign so the caller's next drive lands on a rising edge
        @(posedge sys_clk);
    endtask

    task automatic t_reset;
        logic ack;
        rd_chk(A_STAT, R_STAT);
        rd_chk(A_VSET, R_VSET);
        rd_chk(A_ENC, R_ENC);
        rd_chk(A_OFFC, R_OFFC);
        rd_chk(A_ONC, R_ONC);
        rd_chk(A_REF, R_REF);
        rd_chk(A_LAT, R_LAT);
        rd_chk(8'hab, 8'h00);
        chk({ldo_b_limit_code, ldo_a_limit_code, ldo_a_latch_on}, 5'h1e);
        chk({ldo_b_en, aux_reset_out_n}, 2'h0);
        reg_write(A_REF, 8'h40);
        rd_chk(A_REF, R_REF);
        chk(ldo_vref_sel, 1'b0);
        // A foreign address must not be acknowledged
        i2c_start();
        byte_out({DEV_ADDR ^ 7'h01, 1'b0}, ack);
        i2c_stop();
        chk(ack, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_status;
        ldo_b_pg_cmp <= 1'b1;
        ldo_b_ov_below <= 1'b1;
        ldo_b_ilim_cmp <= 1'b1;
        ldo_b_undervoltage_fault <= 1'b1;
        reg_write(A_STAT, 8'h00);
        rd_chk(A_STAT, 8'he0);
        chk({master_uv_fault_ldo_b, master_ov_fault_ldo_b, master_limit_fault_ldo_b}, 3'h5);
        ldo_b_ov_below <= 1'b0;
        cyc(3);
        chk(master_ov_fault_ldo_b, 1'b1);
        reg_write(A_STAT, 8'h0e);
        chk({master_uv_fault_ldo_b, master_ov_fault_ldo_b, master_limit_fault_ldo_b}, 3'h0);
        rd_chk(A_STAT, 8'hae);
        ldo_b_pg_cmp <= 1'b0;
        ldo_b_ilim_cmp <= 1'b0;
        ldo_b_undervoltage_fault <= 1'b0;
        $display("test status done");
    endtask

    task automatic t_codes;
        logic [7:0] v [3] = '{8'h12, 8'h00, 8'ha5};
        foreach (v[i]) begin
            reg_write(A_VSET, v[i]);
            chk(ldo_b_voltage_code, v[i]);
            rd_chk(A_VSET, v[i]);
        end
        reg_write(A_LAT, 8'h5b);
        chk({ldo_b_limit_code, ldo_a_limit_code, ldo_a_latch_on}, 5'h0d);
        rd_chk(A_LAT, 8'h5b);
        reg_write(A_LAT, R_LAT);
        $display("test codes done");
    endtask

    task automatic t_enable;
        int lo [4] = '{1, Q_CYC, 2 * Q_CYC, 4 * Q_CYC};
        reg_write(A_OFFC, 8'h01);
        ldo_b_direct_permit <= 1'b1;
        wait_en(1'b1, 1, 1);
        chk(aux_reset_out_n, 1'b1);
        ldo_b_direct_permit <= 1'b0;
        wait_en(1'b0, 1, 1);
        chk(aux_reset_out_n, 1'b0);
        reg_write(A_ENC, 8'h40);
        // Every turn-on delay code; long codes may land one clock late
        for (int i = 0; i < 4; i++) begin
            reg_write(A_ONC, 8'h0c | 8'(i));
            ldo_b_seq_en <= 1'b1;
            wait_en(1'b1, lo[i], lo[i] + (i > 0 ? 1 : 0));
            ldo_b_seq_en <= 1'b0;
            wait_en(1'b0, 1, 1);
        end
        reg_write(A_ONC, R_ONC);
        reg_write(A_OFFC, 8'h11);
        ldo_b_seq_en <= 1'b1;
        wait_en(1'b1, 1, 1);
        ldo_b_seq_en <= 1'b0;
        wait_en(1'b0, 2 * Q_CYC, 2 * Q_CYC + 1);
        reg_write(A_OFFC, 8'h01);
        reg_write(A_ONC, 8'h08);
        cyc(2);
        chk(aux_reset_out_n, 1'b1);
        reg_write(A_ONC, R_ONC);
        chk(aux_reset_out_n, 1'b0);
        $display("test enable done");
    endtask

    task automatic t_modes;
        ldo_b_seq_en <= 1'b1;
        wait_en(1'b1, 1, 1);
        // k=0 arms sleep-off, k=1 deep-sleep-off; the other mode must leave it on
        for (int k = 0; k < 2; k++) begin
            reg_write(A_ENC, k == 0 ? 8'h50 : 8'h48);
            {sleep_mode, deep_sleep_mode} <= k == 0 ? 2'b01 : 2'b10;
            cyc(4);
            chk(ldo_b_en, 1'b1);
            {sleep_mode, deep_sleep_mode} <= k == 0 ? 2'b10 : 2'b01;
            wait_en(1'b0, 1, 2);
            {sleep_mode, deep_sleep_mode} <= 2'b00;
            wait_en(1'b1, 1, 2);
        end
        reg_write(A_LAT, 8'hbf);
        ldo_b_seq_en <= 1'b0;
        cyc(10);
        chk(ldo_b_en, 1'b1);
        reg_write(A_LAT, R_LAT);
        cyc(4);
        chk(ldo_b_en, 1'b0);
        reg_write(A_ENC, 8'h40);
        aux_in <= 1'b1;
        cyc(4);
        chk(ldo_b_en, 1'b0);
        reg_write(A_ENC, 8'h60);
        cyc(2);
        chk(ldo_b_en, 1'b1);
        aux_in <= 1'b0;
        wait_en(1'b0, 1, 2);
        reg_write(A_ENC, 8'h40);
        $display("test modes done");
    endtask

    task automatic t_ilim;
        int n;
        logic [7:0] lat [2] = '{8'h3e, 8'h3f};
        int exp [2] = '{RTRY, 0};
        reg_write(A_LAT, 8'h3d);
        ldo_b_seq_en <= 1'b1;
        wait_en(1'b1, 1, 1);
        ldo_b_ilim_cmp <= 1'b1;
        wait_en(1'b0, 1, 1);
        ldo_b_ilim_cmp <= 1'b0;
        wait_en(1'b1, RTRY - 1, RTRY + 2);
        // First regulator: shutdown enabled, then disabled
        for (int k = 0; k < 2; k++) begin
            reg_write(A_LAT, lat[k]);
            ldo_a_ilim_cmp <= 1'b1;
            @(posedge sys_clk);
            ldo_a_ilim_cmp <= 1'b0;
            n = 0;
            repeat (RTRY + 10) begin
                #1;
                if (ldo_a_limit_off === 1'b1) n++;
                @(posedge sys_clk);
            end
            chk(n, exp[k]);
        end
        ldo_b_seq_en <= 1'b0;
        $display("test ilim done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Tests need roughly 40k clocks; cut a hang well beyond that
    initial begin
        repeat (80000) @(posedge sys_clk);
        fails++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        cyc(6);
        reset <= 1'b0;
        cyc(1);
        t_reset();
        t_status();
        t_codes();
        t_enable();
        t_modes();
        t_ilim();
        complete_run();
    end
endmodule
